/* sfsf_asserts.sv */
`timescale 1ns/100ps
module sfsf_asserts #(
    parameter int DEPTH = 64
) (
    input wire logic i_ref_clk,
    input wire logic i_reset,
    input wire logic i_reset_n,
    input wire logic i_write_enable_a_n,
    input wire logic i_write_enable_b_or_load,
    input wire logic i_read_enable_a_n,
    input wire logic i_read_enable_b_n,
    input wire logic o_write_accept,
    input wire logic o_read_accept,
    input wire logic o_empty_n,
    input wire logic o_full_n,
    input wire logic o_almost_empty_n,
    input wire logic o_almost_full_n
);
    // ==========
    // Request decode
    wire logic rd_req = !i_read_enable_a_n && !i_read_enable_b_n;
    wire logic wr_req = !i_write_enable_a_n;

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_reset || !i_reset_n);

    // ==========
    // Flag and accept relations
    chk_full_blocks_wr: assert property (!o_full_n && wr_req |=> !o_write_accept)
        else $error("write accepted while full");
    chk_empty_blocks_rd: assert property (!o_empty_n && rd_req |=> !o_read_accept)
        else $error("read accepted while empty");
    chk_load_no_fifo: assert property (wr_req && !i_write_enable_b_or_load |=> !o_write_accept)
        else $error("fifo write with load pin low");
    chk_wr_cause: assert property (o_write_accept |->
        $past(wr_req) && $past(i_write_enable_b_or_load) && $past(o_full_n))
        else $error("write without cause");
    chk_rd_cause: assert property (o_read_accept |-> $past(rd_req) && $past(o_empty_n))
        else $error("read without cause");
    chk_empty_rise: assert property ($rose(o_empty_n) |-> o_write_accept)
        else $error("empty flag left without a write");
    chk_full_fall: assert property ($fell(o_full_n) |-> o_write_accept && !o_read_accept)
        else $error("full flag set without a write");
    chk_full_afull: assert property (!o_full_n |-> !o_almost_full_n)
        else $error("almost full high while full");
    chk_empty_aempty: assert property (!o_empty_n |-> !o_almost_empty_n)
        else $error("almost empty high while empty");
    chk_write_fills: assert property (o_write_accept && !o_read_accept |-> o_empty_n)
        else $error("empty after a lone write");
    chk_reset_flags: assert property (disable iff (i_reset) !$past(i_reset_n) |->
        !o_empty_n && o_full_n && !o_almost_empty_n && o_almost_full_n)
        else $error("flags wrong after reset");
endmodule : sfsf_asserts

bind sfsf_top sfsf_asserts #(.DEPTH(DEPTH)) u_chk (
    .i_ref_clk(i_ref_clk), .i_reset(i_reset), .i_reset_n(i_reset_n),
    .i_write_enable_a_n(i_write_enable_a_n), .i_write_enable_b_or_load(i_write_enable_b_or_load),
    .i_read_enable_a_n(i_read_enable_a_n), .i_read_enable_b_n(i_read_enable_b_n),
    .o_write_accept(o_write_accept), .o_read_accept(o_read_accept), .o_empty_n(o_empty_n),
    .o_full_n(o_full_n), .o_almost_empty_n(o_almost_empty_n), .o_almost_full_n(o_almost_full_n));

/* sfsf_axil_slave.sv */
`timescale 1ns/100ps
module sfsf_axil_slave #(
    parameter int AW = 8
) (
    input  wire logic          i_ref_clk,
    input  wire logic          i_reset,
    input  wire logic [AW-1:0] s_axil_awaddr,
    input  wire logic          s_axil_awvalid,
    output logic               s_axil_awready,
    input  wire logic [31:0]   s_axil_wdata,
    input  wire logic [3:0]    s_axil_wstrb,
    input  wire logic          s_axil_wvalid,
    output logic               s_axil_wready,
    output logic [1:0]         s_axil_bresp,
    output logic               s_axil_bvalid,
    input  wire logic          s_axil_bready,
    input  wire logic [AW-1:0] s_axil_araddr,
    input  wire logic          s_axil_arvalid,
    output logic               s_axil_arready,
    output logic [31:0]        s_axil_rdata,
    output logic [1:0]         s_axil_rresp,
    output logic               s_axil_rvalid,
    input  wire logic          s_axil_rready,
    output logic               o_wr_en,
    output logic [AW-1:0]      o_wr_addr,
    output logic [31:0]        o_wr_data,
    output logic [3:0]         o_wr_strb,
    input  wire logic          i_wr_ok,
    output logic [AW-1:0]      o_rd_addr,
    input  wire logic [31:0]   i_rd_data,
    input  wire logic          i_rd_ok
);
    logic aw_held_reg;
    logic w_held_reg;

    assign s_axil_awready = !aw_held_reg && !s_axil_bvalid;
    assign s_axil_wready  = !w_held_reg && !s_axil_bvalid;
    assign s_axil_arready = !s_axil_rvalid;
    assign o_rd_addr      = s_axil_araddr;

    // =====================================================
    // Write channel: address and data in either order
    // =====================================================
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            aw_held_reg   <= 1'b0;
            w_held_reg    <= 1'b0;
            o_wr_addr     <= '0;
            o_wr_data     <= 32'h0;
            o_wr_strb     <= 4'h0;
            o_wr_en       <= 1'b0;
            s_axil_bvalid <= 1'b0;
            s_axil_bresp  <= sfsf_pkg::RESP_OKAY;
        end else begin
            o_wr_en <= 1'b0;
            if (s_axil_awvalid && s_axil_awready) begin
                aw_held_reg <= 1'b1;
                o_wr_addr   <= s_axil_awaddr;
            end
            if (s_axil_wvalid && s_axil_wready) begin
                w_held_reg <= 1'b1;
                o_wr_data  <= s_axil_wdata;
                o_wr_strb  <= s_axil_wstrb;
            end
            if (aw_held_reg && w_held_reg && !s_axil_bvalid) begin
                aw_held_reg   <= 1'b0;
                w_held_reg    <= 1'b0;
                o_wr_en       <= i_wr_ok;
                s_axil_bvalid <= 1'b1;
                s_axil_bresp  <= i_wr_ok ? sfsf_pkg::RESP_OKAY : sfsf_pkg::RESP_SLVERR;
            end else if (s_axil_bvalid && s_axil_bready) begin
                s_axil_bvalid <= 1'b0;
            end
        end
    end

    // =====================================================
    // Read channel: one cycle to answer
    // =====================================================
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            s_axil_rvalid <= 1'b0;
            s_axil_rdata  <= 32'h0;
            s_axil_rresp  <= sfsf_pkg::RESP_OKAY;
        end else if (s_axil_arvalid && s_axil_arready) begin
            s_axil_rvalid <= 1'b1;
            s_axil_rdata  <= i_rd_ok ? i_rd_data : 32'h0;
            s_axil_rresp  <= i_rd_ok ? sfsf_pkg::RESP_OKAY : sfsf_pkg::RESP_SLVERR;
        end else if (s_axil_rvalid && s_axil_rready) begin
            s_axil_rvalid <= 1'b0;
        end
    end
endmodule : sfsf_axil_slave

/* sfsf_fifo_peer.sv */
`timescale 1ns/100ps
module sfsf_fifo_peer (
    input  wire logic i_in_reset,
    input  wire logic i_dual,
    input  wire logic i_wr,
    input  wire logic i_rd,
    input  wire logic i_ofs,
    input  wire logic i_empty_n,
    input  wire logic i_full_n,
    output logic      o_write_enable_a_n,
    output logic      o_write_enable_b_or_load,
    output logic      o_read_enable_a_n,
    output logic      o_read_enable_b_n,
    output logic      o_empty_all_n,
    output logic      o_full_all_n
);
    // ==========
    // Pin drive, mode strap held through reset
    assign o_write_enable_b_or_load = i_in_reset ? i_dual : !i_ofs;
    assign o_write_enable_a_n       = !i_wr;
    // Never read and write the offsets in one cycle
    assign o_read_enable_a_n        = !(i_rd && !(i_ofs && i_wr));
    assign o_read_enable_b_n        = o_read_enable_a_n;
    // One device only, so the composite is the device flag
    assign o_empty_all_n            = i_empty_n;
    assign o_full_all_n             = i_full_n;
endmodule : sfsf_fifo_peer

/* sfsf_pkg.sv */
// What this block does
// - Empty threshold n joins empty-offset low and high bytes.
// - Almost-empty flag low when unread words are n or fewer.
// - Almost-empty flag rises on a read edge at n+1 or more words.
// - Almost-empty flag comes from a single flip-flop on the read clock.
// - Full threshold m joins full-offset low and high bytes.
// - Almost-full flag low when unread words reach depth minus m.
// - Almost-full flag rises on a write edge when more than m locations free.
// - Almost-full flag comes from a single flip-flop on the write clock.
// - Load and enable low write offsets in rotation; other combinations per table.
// - Offsets read back in same rotation with load and both read enables low.
// - Empty threshold n defaults to 7 after reset.
// - Full threshold m defaults to 7 after reset.
// - Full flag low when words held equal the depth.
// - Writes ignored while full flag low, whatever the enables.
// - Full flag updated only on write clock edges.
// - Empty flag low when zero words held.
// - Reads ignored while empty flag low, whatever the enables.
// - Empty flag updated only on read clock edges.
// - Load pin sampled during reset; high selects dual write-enable mode (sampled on i_reset_n only; i_reset clears to single mode).
// - Offset pointer persists when load pin returns high.
// - Reset clears pointers so the FIFO is empty with empty flag low.
package sfsf_pkg;
    // Offset register rotation slots
    localparam logic [1:0] OFS_EMPTY_LO = 2'h0;
    localparam logic [1:0] OFS_EMPTY_HI = 2'h1;
    localparam logic [1:0] OFS_FULL_LO  = 2'h2;
    localparam logic [1:0] OFS_FULL_HI  = 2'h3;
    localparam int         OFS_COUNT    = 4;
    localparam logic [7:0] OFS_LO_RESET = 8'h07;
    localparam logic [7:0] OFS_HI_RESET = 8'h00;

    // Bus register byte offsets
    localparam logic [7:0] REG_CTRL     = 8'h00;
    localparam logic [7:0] REG_STATUS   = 8'h04;
    localparam logic [7:0] REG_THRESH   = 8'h08;

    // Field positions
    localparam int CTRL_FLUSH_BIT   = 0;
    localparam int STAT_EMPTY_BIT   = 0;
    localparam int STAT_AEMPTY_BIT  = 1;
    localparam int STAT_AFULL_BIT   = 2;
    localparam int STAT_FULL_BIT    = 3;
    localparam int STAT_DUAL_BIT    = 4;
    localparam int STAT_COUNT_POS   = 16;
    localparam int THRESH_FULL_POS  = 16;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : sfsf_pkg

/* sfsf_top.sv */
`timescale 1ns/100ps
module sfsf_top #(
    parameter int DEPTH  = 64,
    parameter int AXI_AW = 8
) (
    input  wire logic              i_ref_clk,
    input  wire logic              i_reset,
    input  wire logic              i_reset_n,
    input  wire logic              i_write_enable_a_n,
    input  wire logic              i_write_enable_b_or_load,
    input  wire logic              i_read_enable_a_n,
    input  wire logic              i_read_enable_b_n,
    input  wire logic [8:0]        i_data,
    output logic [8:0]             o_data,
    output logic                   o_write_accept,
    output logic                   o_read_accept,
    output logic                   o_empty_n,
    output logic                   o_full_n,
    output logic                   o_almost_empty_n,
    output logic                   o_almost_full_n,
    input  wire logic [AXI_AW-1:0] s_axil_awaddr,
    input  wire logic              s_axil_awvalid,
    output logic                   s_axil_awready,
    input  wire logic [31:0]       s_axil_wdata,
    input  wire logic [3:0]        s_axil_wstrb,
    input  wire logic              s_axil_wvalid,
    output logic                   s_axil_wready,
    output logic [1:0]             s_axil_bresp,
    output logic                   s_axil_bvalid,
    input  wire logic              s_axil_bready,
    input  wire logic [AXI_AW-1:0] s_axil_araddr,
    input  wire logic              s_axil_arvalid,
    output logic                   s_axil_arready,
    output logic [31:0]            s_axil_rdata,
    output logic [1:0]             s_axil_rresp,
    output logic                   s_axil_rvalid,
    input  wire logic              s_axil_rready
);
    localparam int              AW      = $clog2(DEPTH);
    localparam int              CW      = AW + 1;
    localparam logic [CW-1:0]   DEPTH_C = CW'(DEPTH);

    // =====================================================
    // Declarations
    // =====================================================
    logic [CW-1:0]     wr_ptr_reg;
    logic [CW-1:0]     rd_ptr_reg;
    logic [CW-1:0]     wr_ptr_next;
    logic [CW-1:0]     rd_ptr_next;
    logic [CW-1:0]     count_reg;
    logic [CW-1:0]     count_next;
    logic [7:0]        offset_reg [sfsf_pkg::OFS_COUNT];
    logic [1:0]        ofs_sel_reg;
    logic              dual_mode_reg;
    logic              empty_n_reg;
    logic              full_n_reg;
    logic              almost_empty_n_reg;
    logic              almost_full_n_reg;
    logic [8:0]        data_reg;
    logic              offset_load_n;
    logic              ofs_write;
    logic              ofs_read;
    logic              fifo_write;
    logic              fifo_read;
    logic              pin_reset;
    logic              flush;
    logic [15:0]       empty_ofs_word;
    logic [15:0]       full_ofs_word;
    logic [CW-1:0]     n_thr;
    logic [CW-1:0]     m_thr;
    logic [CW-1:0]     free_next;
    logic              bus_wr_en;
    logic [AXI_AW-1:0] bus_wr_addr;
    logic [31:0]       bus_wr_data;
    logic [3:0]        bus_wr_strb;
    logic              bus_wr_ok;
    logic [AXI_AW-1:0] bus_rd_addr;
    logic [31:0]       bus_rd_data;
    logic              bus_rd_ok;

    // =====================================================
    // Mode and request decode
    // =====================================================
    // Pin reset clears the same FIFO state as the bus-side reset, leaves the bus slave alone, and also catches the mode strap
    assign pin_reset     = !i_reset_n;
    assign flush         = bus_wr_en && bus_wr_addr == AXI_AW'(sfsf_pkg::REG_CTRL)
                           && bus_wr_strb[0] && bus_wr_data[sfsf_pkg::CTRL_FLUSH_BIT];
    assign offset_load_n = dual_mode_reg || i_write_enable_b_or_load;

    always_comb begin
        ofs_write  = !offset_load_n && !i_write_enable_a_n;
        ofs_read   = !offset_load_n && !i_read_enable_a_n
                     && !i_read_enable_b_n && !ofs_write;
        // Load high and enable low writes the FIFO; full blocks it
        fifo_write = !i_write_enable_a_n && i_write_enable_b_or_load
                     && full_n_reg;
        // Reads blocked when empty or when the load pin selects offsets
        fifo_read  = !i_read_enable_a_n && !i_read_enable_b_n
                     && offset_load_n && empty_n_reg;
    end

    // =====================================================
    // Mode strap
    // =====================================================
    always_ff @(posedge i_ref_clk) begin
        if (i_reset) begin
            dual_mode_reg <= 1'b0;
        end else if (pin_reset) begin
            dual_mode_reg <= i_write_enable_b_or_load;
        end
    end

    // =====================================================
    // Offset registers
    // =====================================================
    generate
        for (genvar g = 0; g < sfsf_pkg::OFS_COUNT; g++) begin : g_ofs
            localparam logic [7:0] RST_VAL =
                (g == int'(sfsf_pkg::OFS_EMPTY_LO) || g == int'(sfsf_pkg::OFS_FULL_LO))
                ? sfsf_pkg::OFS_LO_RESET : sfsf_pkg::OFS_HI_RESET;
            always_ff @(posedge i_ref_clk) begin
                if (i_reset || pin_reset) begin
                    offset_reg[g] <= RST_VAL;
                end else if (ofs_write && ofs_sel_reg == 2'(g)) begin
                    offset_reg[g] <= i_data[7:0];
                end
            end
        end
    endgenerate

    // Rotation pointer survives load pin going high
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || pin_reset) begin
            ofs_sel_reg <= sfsf_pkg::OFS_EMPTY_LO;
        end else if (ofs_write || ofs_read) begin
            ofs_sel_reg <= ofs_sel_reg + 2'h1;
        end
    end

    // Data outputs hold the last offset read back
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || pin_reset) begin
            data_reg <= 9'h000;
        end else if (ofs_read) begin
            data_reg <= {1'b0, offset_reg[ofs_sel_reg]};
        end
    end

    // =====================================================
    // Thresholds
    // =====================================================
    // Upper offset bits beyond the address width are dropped
    assign empty_ofs_word = {offset_reg[sfsf_pkg::OFS_EMPTY_HI],
                             offset_reg[sfsf_pkg::OFS_EMPTY_LO]};
    assign full_ofs_word  = {offset_reg[sfsf_pkg::OFS_FULL_HI],
                             offset_reg[sfsf_pkg::OFS_FULL_LO]};
    assign n_thr          = {1'b0, empty_ofs_word[AW-1:0]};
    assign m_thr          = {1'b0, full_ofs_word[AW-1:0]};

    // =====================================================
    // Pointers and count
    // =====================================================
    always_comb begin
        wr_ptr_next = wr_ptr_reg;
        rd_ptr_next = rd_ptr_reg;
        if (fifo_write) begin
            wr_ptr_next = wr_ptr_reg + CW'(1);
        end
        if (fifo_read) begin
            rd_ptr_next = rd_ptr_reg + CW'(1);
        end
        if (flush) begin
            wr_ptr_next = '0;
            rd_ptr_next = '0;
        end
        count_next = wr_ptr_next - rd_ptr_next;
        free_next  = DEPTH_C - count_next;
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_reset || pin_reset) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            wr_ptr_reg <= wr_ptr_next;
            rd_ptr_reg <= rd_ptr_next;
            count_reg  <= count_next;
        end
    end

    // =====================================================
    // Read-side flags
    // =====================================================
    // One register stage each; no extra synchroniser latency
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || pin_reset) begin
            empty_n_reg        <= 1'b0;
            almost_empty_n_reg <= 1'b0;
        end else begin
            empty_n_reg        <= count_next != '0;
            almost_empty_n_reg <= count_next > n_thr;
        end
    end

    // =====================================================
    // Write-side flags
    // =====================================================
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || pin_reset) begin
            full_n_reg        <= 1'b1;
            almost_full_n_reg <= 1'b1;
        end else begin
            full_n_reg        <= count_next != DEPTH_C;
            almost_full_n_reg <= free_next > m_thr;
        end
    end

    // Accept strobes registered to match the flag timing
    always_ff @(posedge i_ref_clk) begin
        if (i_reset || pin_reset) begin
            o_write_accept <= 1'b0;
            o_read_accept  <= 1'b0;
        end else begin
            o_write_accept <= fifo_write;
            o_read_accept  <= fifo_read;
        end
    end

    assign o_data           = data_reg;
    assign o_empty_n        = empty_n_reg;
    assign o_full_n         = full_n_reg;
    assign o_almost_empty_n = almost_empty_n_reg;
    assign o_almost_full_n  = almost_full_n_reg;

    // =====================================================
    // Register bus
    // =====================================================
    assign bus_wr_ok = bus_wr_addr == AXI_AW'(sfsf_pkg::REG_CTRL);

    always_comb begin
        bus_rd_data = 32'h0;
        bus_rd_ok   = 1'b1;
        if (bus_rd_addr == AXI_AW'(sfsf_pkg::REG_CTRL)) begin
            bus_rd_data = 32'h0;
        end else if (bus_rd_addr == AXI_AW'(sfsf_pkg::REG_STATUS)) begin
            bus_rd_data[sfsf_pkg::STAT_EMPTY_BIT]  = empty_n_reg;
            bus_rd_data[sfsf_pkg::STAT_AEMPTY_BIT] = almost_empty_n_reg;
            bus_rd_data[sfsf_pkg::STAT_AFULL_BIT]  = almost_full_n_reg;
            bus_rd_data[sfsf_pkg::STAT_FULL_BIT]   = full_n_reg;
            bus_rd_data[sfsf_pkg::STAT_DUAL_BIT]   = dual_mode_reg;
            bus_rd_data[sfsf_pkg::STAT_COUNT_POS +: CW] = count_reg;
        end else if (bus_rd_addr == AXI_AW'(sfsf_pkg::REG_THRESH)) begin
            bus_rd_data[CW-1:0] = n_thr;
            bus_rd_data[sfsf_pkg::THRESH_FULL_POS +: CW] = m_thr;
        end else begin
            bus_rd_ok = 1'b0;
        end
    end

    sfsf_axil_slave #(
        .AW (AXI_AW)
    ) u_axil (
        .i_ref_clk      (i_ref_clk),
        .i_reset        (i_reset),
        .s_axil_awaddr  (s_axil_awaddr),
        .s_axil_awvalid (s_axil_awvalid),
        .s_axil_awready (s_axil_awready),
        .s_axil_wdata   (s_axil_wdata),
        .s_axil_wstrb   (s_axil_wstrb),
        .s_axil_wvalid  (s_axil_wvalid),
        .s_axil_wready  (s_axil_wready),
        .s_axil_bresp   (s_axil_bresp),
        .s_axil_bvalid  (s_axil_bvalid),
        .s_axil_bready  (s_axil_bready),
        .s_axil_araddr  (s_axil_araddr),
        .s_axil_arvalid (s_axil_arvalid),
        .s_axil_arready (s_axil_arready),
        .s_axil_rdata   (s_axil_rdata),
        .s_axil_rresp   (s_axil_rresp),
        .s_axil_rvalid  (s_axil_rvalid),
        .s_axil_rready  (s_axil_rready),
        .o_wr_en        (bus_wr_en),
        .o_wr_addr      (bus_wr_addr),
        .o_wr_data      (bus_wr_data),
        .o_wr_strb      (bus_wr_strb),
        .i_wr_ok        (bus_wr_ok),
        .o_rd_addr      (bus_rd_addr),
        .i_rd_data      (bus_rd_data),
        .i_rd_ok        (bus_rd_ok)
    );
endmodule : sfsf_top

/* sfsf_top_test.sv */
`timescale 1ns/100ps
module sfsf_top_test;
    localparam int DEP = 64;
    logic clk = 1'b0, rst = 1'b1, rst_n = 1'b1, wr = 1'b0, rd = 1'b0, ofs = 1'b0, dual = 1'b0;
    logic [8:0] din = 9'h000, dout, mdout;
    logic wa_n, ld, ra_n, rb_n, w_acc, r_acc, e_n, f_n, ae_n, af_n, mdual, mwa, mra;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [7:0] ofr [4];
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [31:0] wdata = 32'h0, rdata;
    logic [1:0] bresp, rresp;
    int error_cnt = 0, n_tests = 0, cyc = 0, cnt, rot;

    always #50 clk = ~clk;

    sfsf_top #(.DEPTH(DEP)) uut (
        .i_ref_clk(clk), .i_reset(rst), .i_reset_n(rst_n), .i_write_enable_a_n(wa_n),
        .i_write_enable_b_or_load(ld), .i_read_enable_a_n(ra_n), .i_read_enable_b_n(rb_n),
        .i_data(din), .o_data(dout), .o_write_accept(w_acc), .o_read_accept(r_acc),
        .o_empty_n(e_n), .o_full_n(f_n), .o_almost_empty_n(ae_n), .o_almost_full_n(af_n),
        .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid), .s_axil_awready(awready),
        .s_axil_wdata(wdata), .s_axil_wstrb(4'hf), .s_axil_wvalid(wvalid),
        .s_axil_wready(wready), .s_axil_bresp(bresp), .s_axil_bvalid(bvalid),
        .s_axil_bready(bready), .s_axil_araddr(araddr), .s_axil_arvalid(arvalid),
        .s_axil_arready(arready), .s_axil_rdata(rdata), .s_axil_rresp(rresp),
        .s_axil_rvalid(rvalid), .s_axil_rready(rready));

    sfsf_fifo_peer u_peer (
        .i_in_reset(!rst_n), .i_dual(dual), .i_wr(wr), .i_rd(rd), .i_ofs(ofs), .i_empty_n(e_n),
        .i_full_n(f_n), .o_write_enable_a_n(wa_n), .o_write_enable_b_or_load(ld),
        .o_read_enable_a_n(ra_n), .o_read_enable_b_n(rb_n), .o_empty_all_n(), .o_full_all_n());

    // ==========
    // Reporting
    task automatic chkw(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chkw

    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : wrap_up

    // Whole run is under 2000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc > 6000) begin
            error_cnt++;
            wrap_up();
        end
    end

    // ==========
    // Reference model
    function automatic int thr(input int k);
        return {ofr[2*k+1], ofr[2*k]} % DEP;
    endfunction : thr

    task automatic do_reset(input logic dev, input logic dm);
        wr <= 1'b0;
        rd <= 1'b0;
        dual <= dm;
        if (dev) rst_n <= 1'b0;
        else rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        rst_n <= 1'b1;
        cnt = 0;
        rot = 0;
        mdout = 9'h000;
        mdual = dev && dm;
        ofr = '{8'h07, 8'h00, 8'h07, 8'h00};
    endtask : do_reset

    task automatic run(input int cycles, input int pw, input int pr, input int po);
        logic rde, pofs;
        int t0, t1;
        for (int k = 0; k <= cycles; k++) begin
            @(posedge clk);
            // Flags use offsets held before this edge
            t0 = thr(0);
            t1 = thr(1);
            pofs = !mdual && ofs;
            rde = rd && !(ofs && wr);
            mwa = wr && !ofs && cnt < DEP;
            mra = rde && !pofs && cnt > 0;
            if (pofs && wr) begin
                ofr[rot] = din[7:0];
                rot = (rot + 1) % 4;
            end else if (pofs && rde) begin
                mdout = {1'b0, ofr[rot]};
                rot = (rot + 1) % 4;
            end
            cnt = cnt + mwa - mra;
            // Last step drives idle so nothing is pending on exit
            wr <= (k < cycles) && ($urandom % 100) < pw;
            rd <= (k < cycles) && ($urandom % 100) < pr;
            ofs <= ($urandom % 100) < po;
            din <= 9'($urandom);
            @(negedge clk);
            chkw("write_accept", 32'(mwa), 32'(w_acc));
            chkw("read_accept", 32'(mra), 32'(r_acc));
            chkw("empty_n", 32'(cnt != 0), 32'(e_n));
            chkw("full_n", 32'(cnt != DEP), 32'(f_n));
            chkw("almost_empty_n", 32'(cnt > t0), 32'(ae_n));
            chkw("almost_full_n", 32'(DEP - cnt > t1), 32'(af_n));
            chkw("offset_data", 32'(mdout), 32'(dout));
        end
    endtask : run

    // ==========
    // Register bus master
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ha, hw, hb;
        hb = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!hb) begin
            @(negedge clk);
            ha = awvalid && awready;
            hw = wvalid && wready;
            hb = bvalid && bready;
            r = bresp;
            @(posedge clk);
            if (ha) awvalid <= 1'b0;
            if (hw) wvalid <= 1'b0;
            if (hb) bready <= 1'b0;
        end
    endtask : axw

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ha, hb;
        hb = 1'b0;
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (!hb) begin
            @(negedge clk);
            ha = arvalid && arready;
            hb = rvalid && rready;
            d = rdata;
            r = rresp;
            @(posedge clk);
            if (ha) arvalid <= 1'b0;
            if (hb) rready <= 1'b0;
        end
    endtask : axr

    task automatic stat_chk();
        logic [31:0] d, e;
        logic [1:0] r;
        axr(sfsf_pkg::REG_STATUS, d, r);
        e = {9'h0, 7'(cnt), 11'h0, mdual, 1'(cnt != DEP), 1'(DEP - cnt > thr(1)),
             1'(cnt > thr(0)), 1'(cnt != 0)};
        chkw("status", e, d);
    endtask : stat_chk

    // ==========
    // Main sequence
    initial begin
        logic [31:0] d;
        logic [1:0] r;
        d = $urandom(32'h849dda48);
        do_reset(1'b0, 1'b0);
        axr(sfsf_pkg::REG_THRESH, d, r);
        chkw("thresh", 32'h0007_0007, d & 32'h003f_003f);
        run(6, 100, 0, 100);
        run(8, 0, 100, 100);
        run(200, 60, 40, 5);
        run(150, 90, 10, 5);
        stat_chk();
        run(150, 10, 90, 5);
        run(150, 50, 50, 8);
        stat_chk();
        axw(sfsf_pkg::REG_CTRL, 32'h1, r);
        repeat (2) @(posedge clk);
        cnt = 0;
        stat_chk();
        axr(8'h0c, d, r);
        chkw("bad_read", 32'(sfsf_pkg::RESP_SLVERR), 32'(r));
        axw(8'h10, 32'hffff_ffff, r);
        chkw("bad_write", 32'(sfsf_pkg::RESP_SLVERR), 32'(r));
        run(60, 80, 20, 5);
        @(posedge clk);
        do_reset(1'b1, 1'b1);
        run(200, 60, 40, 20);
        stat_chk();
        @(posedge clk);
        do_reset(1'b1, 1'b0);
        run(100, 70, 30, 10);
        wrap_up();
    end
endmodule : sfsf_top_test
